/* File: pep2_consts.svh */
`ifndef PEP2_CONSTS_SVH
`define PEP2_CONSTS_SVH
`define PEP2_IDX_EEE_CTRL 5'h11
`define PEP2_IDX_CHIP_ID 5'h12
`define PEP2_IDX_ENTROPY 5'h13
`define PEP2_IDX_EV_ENABLE 5'h1c
`define PEP2_IDX_EV_PENDING 5'h1d
`define PEP2_IDX_PAGE_SEL 5'h1f
`define PEP2_IDX_PAGED_LO 5'h10
`define PEP2_IDX_PAGED_HI 5'h1e
`define PEP2_PAGE_EXT2 16'h0002
`define PEP2_PAGE_MAIN 16'h0000
`define PEP2_CTRL_RST 16'h0000
`define PEP2_CTRL_RW_MASK 16'hfc3f
`define PEP2_B_TE10 15
`define PEP2_B_LED_UNI 14
`define PEP2_F_LED_INV_HI 13
`define PEP2_F_LED_INV_LO 10
`define PEP2_B_LINK 8
`define PEP2_B_EEE1000 7
`define PEP2_B_EEE100 6
`define PEP2_B_FORCE1000 5
`define PEP2_B_FORCE_LPI 4
`define PEP2_B_INH_TX100 3
`define PEP2_B_INH_RX100 2
`define PEP2_B_INH_TX1000 1
`define PEP2_B_INH_RX1000 0
`define PEP2_SPEED_1000 2'h2
`define PEP2_EV_RST 11'h000
`define PEP2_EV_W 11
`define PEP2_ENT_SEED 32'h1234_5679
`define PEP2_ENT_TAPS 32'h8020_0003
`endif

/* File: pep2_pkg.sv */
package pep2_pkg;
    typedef enum logic [0:0] {
        PEP2_IDLE = 1'b0,
        PEP2_ACK = 1'b1
    } pep2_bus_st_t;
endpackage

/* File: pep2_ent_if.sv */
`timescale 1ns/1ps
interface pep2_ent_if;
    logic [15:0] word;
    logic take;
    modport src (output word, input take);
    modport snk (input word, output take);
endinterface

/* File: pep2_entropy.sv */
`timescale 1ns/1ps
`include "pep2_consts.svh"
module pep2_entropy (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_stir,
    pep2_ent_if.src ent
);
    logic [31:0] lfsr_q;
    logic [31:0] lfsr_d;
    // free-running galois shift; the stir input folds in outside activity
    always_comb begin
        lfsr_d = {1'b0, lfsr_q[31:1]};
        if (lfsr_q[0]) begin
            lfsr_d = lfsr_d ^ `PEP2_ENT_TAPS;
        end
        lfsr_d[31] = lfsr_d[31] ^ i_stir;
        if (ent.take) begin
            lfsr_d = lfsr_d ^ {lfsr_q[15:0], lfsr_q[31:16]};
        end
        if (lfsr_d == 32'h0000_0000) begin
            lfsr_d = `PEP2_ENT_SEED;
        end
    end
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            lfsr_q <= `PEP2_ENT_SEED;
        end else begin
            lfsr_q <= lfsr_d;
        end
    end
    assign ent.word = lfsr_q[31:16] ^ lfsr_q[15:0];
    a_ent_moves: assert property (@(posedge i_clock) disable iff (i_reset)
        lfsr_q != 32'h0000_0000) else $error("entropy state stuck at zero");
endmodule

/* File: pep2_regs.sv */
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pep2_consts.svh"
module pep2_regs #(
    parameter logic P_INDUSTRIAL = 1'b0,
    parameter logic P_QUAD = 1'b1,
    parameter logic P_MACSEC = 1'b1,
    parameter logic P_DUAL_MEDIA = 1'b1,
    parameter logic P_KEY256 = 1'b1,
    // arbitrary variant code, not a real suffix
    parameter logic [7:0] P_VARIANT_BCD = 8'h00
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_soft_reset,
    input wire logic [6:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_link_up,
    input wire logic i_eee_1000_active,
    input wire logic i_eee_100_active,
    input wire logic [1:0] i_speed_select,
    input wire logic i_mode_100,
    input wire logic i_mode_1000,
    input wire logic i_tx_lpi_from_mac,
    input wire logic i_rx_lpi_from_line,
    input wire logic i_fiber_unidir,
    input wire logic [15:0] i_indicator_raw,
    input wire logic [10:0] i_events,
    output logic [15:0] o_indicator_outputs,
    output logic o_te10_enable,
    output logic o_force_1000,
    output logic o_ignore_mac_data,
    output logic o_tx_lpi_line,
    output logic o_rx_lpi_mac,
    output logic o_irq
);
    pep2_pkg::pep2_bus_st_t state_q;
    logic [15:0] ctrl_q;
    logic [15:0] page_q;
    logic [10:0] enable_q;
    logic [10:0] pending_q;
    logic [10:0] pending_d;
    logic [10:0] read_snap_q;
    logic snap_valid_q;
    logic [31:0] rdata_q;
    logic wait_q;
    logic [4:0] idx;
    logic on_page2;
    logic paged;
    logic accept;
    logic wr_go;
    logic rd_go;
    logic [15:0] wdata;
    logic [15:0] chip_word;
    logic [15:0] ctrl_view;
    logic [15:0] rd_word;
    logic [3:0] inv;
    pep2_ent_if ent ();

    pep2_entropy u_entropy (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_stir(i_link_up ^ i_rx_lpi_from_line),
        .ent(ent)
    );

    assign idx = i_avs_address[6:2];
    assign wdata = i_avs_writedata[15:0];
    assign on_page2 = (page_q == `PEP2_PAGE_EXT2);
    assign paged = (idx >= `PEP2_IDX_PAGED_LO) && (idx <= `PEP2_IDX_PAGED_HI);
    assign accept = (state_q == pep2_pkg::PEP2_IDLE) && (i_avs_read || i_avs_write);
    // the request is taken on the edge where waitrequest is seen low
    assign wr_go = (state_q == pep2_pkg::PEP2_ACK) && i_avs_write && (&i_avs_byteenable[1:0]);
    assign rd_go = (state_q == pep2_pkg::PEP2_ACK) && i_avs_read;
    assign ent.take = rd_go && on_page2 && (idx == `PEP2_IDX_ENTROPY);

    assign chip_word = {P_INDUSTRIAL, P_QUAD, 1'b0, P_MACSEC, 1'b0, P_DUAL_MEDIA,
        1'b0, P_KEY256, P_VARIANT_BCD};

    always_comb begin
        ctrl_view = ctrl_q & `PEP2_CTRL_RW_MASK;
        ctrl_view[`PEP2_B_LINK] = i_link_up;
        ctrl_view[`PEP2_B_EEE1000] = i_eee_1000_active;
        ctrl_view[`PEP2_B_EEE100] = i_eee_100_active;
    end

    // pages 16-30 answer only when page 2 is selected; main-set offsets read zero here
    always_comb begin
        rd_word = 16'h0000;
        if (idx == `PEP2_IDX_PAGE_SEL) begin
            rd_word = page_q;
        end else if (paged && on_page2 && idx == `PEP2_IDX_EEE_CTRL) begin
            rd_word = ctrl_view;
        end else if (paged && on_page2 && idx == `PEP2_IDX_CHIP_ID) begin
            rd_word = chip_word;
        end else if (paged && on_page2 && idx == `PEP2_IDX_ENTROPY) begin
            rd_word = ent.word;
        end else if (paged && on_page2 && idx == `PEP2_IDX_EV_ENABLE) begin
            rd_word = {5'h00, enable_q};
        end else if (paged && on_page2 && idx == `PEP2_IDX_EV_PENDING) begin
            rd_word = {5'h00, pending_q};
        end
    end

    // one wait state: sample in IDLE, answer in ACK
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_q <= pep2_pkg::PEP2_IDLE;
            wait_q <= 1'b1;
        end else if (accept) begin
            state_q <= pep2_pkg::PEP2_ACK;
            wait_q <= 1'b0;
        end else begin
            state_q <= pep2_pkg::PEP2_IDLE;
            wait_q <= 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            rdata_q <= 32'h0000_0000;
        end else if (accept && i_avs_read) begin
            rdata_q <= {16'h0000, rd_word};
        end
    end

    // only bits actually shown to software are cleared by the read
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            read_snap_q <= `PEP2_EV_RST;
            snap_valid_q <= 1'b0;
        end else if (accept && i_avs_read) begin
            read_snap_q <= rd_word[10:0];
            snap_valid_q <= paged && on_page2 && (idx == `PEP2_IDX_EV_PENDING);
        end else begin
            snap_valid_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            page_q <= `PEP2_PAGE_MAIN;
        end else if (i_soft_reset) begin
            page_q <= `PEP2_PAGE_MAIN;
        end else if (wr_go && idx == `PEP2_IDX_PAGE_SEL) begin
            page_q <= wdata;
        end
    end

    // sticky: soft port reset leaves these alone
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            ctrl_q <= `PEP2_CTRL_RST;
        end else if (wr_go && on_page2 && idx == `PEP2_IDX_EEE_CTRL) begin
            ctrl_q <= wdata & `PEP2_CTRL_RW_MASK;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            enable_q <= `PEP2_EV_RST;
        end else if (wr_go && on_page2 && idx == `PEP2_IDX_EV_ENABLE) begin
            enable_q <= wdata[10:0];
        end
    end

    always_comb begin
        pending_d = pending_q;
        if (rd_go && snap_valid_q) begin
            pending_d = pending_d & ~read_snap_q;
        end
        if (i_soft_reset) begin
            pending_d = `PEP2_EV_RST;
        end
        pending_d = pending_d | i_events;
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            pending_q <= `PEP2_EV_RST;
        end else begin
            pending_q <= pending_d;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(pending_q & enable_q);
        end
    end

    assign inv = ctrl_q[`PEP2_F_LED_INV_HI:`PEP2_F_LED_INV_LO];

    // raw indicator is active high; pins idle high unless inverted
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_indicator_outputs <= 16'hffff;
        end else begin
            for (int g = 0; g < 4; g++) begin
                if (i_fiber_unidir && !ctrl_q[`PEP2_B_LED_UNI]) begin
                    o_indicator_outputs[g*4 +: 4] <= {4{~inv[g]}};
                end else begin
                    o_indicator_outputs[g*4 +: 4] <= ~i_indicator_raw[g*4 +: 4]
                        ^ {4{inv[g]}};
                end
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_te10_enable <= 1'b0;
            o_force_1000 <= 1'b0;
            o_ignore_mac_data <= 1'b0;
        end else begin
            o_te10_enable <= ctrl_q[`PEP2_B_TE10];
            o_force_1000 <= ctrl_q[`PEP2_B_FORCE1000]
                && (i_speed_select == `PEP2_SPEED_1000);
            o_ignore_mac_data <= ctrl_q[`PEP2_B_FORCE_LPI];
        end
    end

    // debug inhibits, software keeps them clear in service
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_tx_lpi_line <= 1'b0;
            o_rx_lpi_mac <= 1'b0;
        end else begin
            o_tx_lpi_line <= ctrl_q[`PEP2_B_FORCE_LPI]
                || (i_tx_lpi_from_mac
                && !(i_mode_100 && ctrl_q[`PEP2_B_INH_TX100])
                && !(i_mode_1000 && ctrl_q[`PEP2_B_INH_TX1000]));
            o_rx_lpi_mac <= i_rx_lpi_from_line
                && !(i_mode_100 && ctrl_q[`PEP2_B_INH_RX100])
                && !(i_mode_1000 && ctrl_q[`PEP2_B_INH_RX1000]);
        end
    end

    assign o_avs_readdata = rdata_q;
    assign o_avs_waitrequest = wait_q;

    a_ctrl_hw_reset: assert property (@(posedge i_clock)
        i_reset |=> ctrl_q == 16'h0000 && enable_q == 11'h000)
        else $error("control or mask not cleared by reset");
    a_sticky_soft_reset: assert property (@(posedge i_clock) disable iff (i_reset)
        i_soft_reset && !wr_go |=> ctrl_q == $past(ctrl_q) && enable_q == $past(enable_q))
        else $error("sticky bit lost on soft reset");
    a_page_return: assert property (@(posedge i_clock) disable iff (i_reset || i_soft_reset)
        wr_go && idx == `PEP2_IDX_PAGE_SEL && wdata == `PEP2_PAGE_MAIN |=> !on_page2)
        else $error("page not restored to main");
    a_pend_set_wins: assert property (@(posedge i_clock) disable iff (i_reset)
        i_events[4] |=> pending_q[4])
        else $error("event lost");
    a_irq_follows: assert property (@(posedge i_clock) disable iff (i_reset)
        |(pending_q & enable_q) |=> o_irq)
        else $error("interrupt not raised");
    a_read_clears: assert property (@(posedge i_clock) disable iff (i_reset || i_soft_reset)
        rd_go && snap_valid_q && i_events == 11'h000 |=> (pending_q & $past(read_snap_q)) == 0)
        else $error("status read did not clear");
    a_force_speed: assert property (@(posedge i_clock) disable iff (i_reset)
        o_force_1000 |-> $past(ctrl_q[5]) && $past(i_speed_select) == 2'b10)
        else $error("forced gigabit without speed select");
    a_tx_inhibit: assert property (@(posedge i_clock) disable iff (i_reset)
        ctrl_q[1] && i_mode_1000 && !ctrl_q[4] ##1 ctrl_q[1] |-> !o_tx_lpi_line)
        else $error("lpi sent while inhibited");
    a_rx_inhibit: assert property (@(posedge i_clock) disable iff (i_reset)
        ctrl_q[2] && i_mode_100 |=> !o_rx_lpi_mac)
        else $error("lpi passed while inhibited");
    a_bus_answer: assert property (@(posedge i_clock) disable iff (i_reset)
        accept |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("bus answer not one wait state");
    a_led_default: assert property (@(posedge i_clock) disable iff (i_reset)
        inv == 4'h0 && !i_fiber_unidir && i_indicator_raw[0] ##1 inv == 4'h0
        |-> !o_indicator_outputs[0])
        else $error("indicator not active low");
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam logic [6:0] A_CTRL = 7'h44;
    localparam logic [6:0] A_CHIP = 7'h48;
    localparam logic [6:0] A_ENT = 7'h4c;
    localparam logic [6:0] A_MASK = 7'h70;
    localparam logic [6:0] A_STAT = 7'h74;
    localparam logic [6:0] A_PAGE = 7'h7c;
    logic i_clock, i_reset, i_soft_reset, i_avs_read, i_avs_write;
    logic [6:0] i_avs_address;
    logic [31:0] i_avs_writedata;
    logic [3:0] i_avs_byteenable;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest, o_te10_enable, o_force_1000, o_ignore_mac_data;
    logic o_tx_lpi_line, o_rx_lpi_mac, o_irq;
    logic i_link_up, i_eee_1000_active, i_eee_100_active, i_mode_100, i_mode_1000;
    logic i_tx_lpi_from_mac, i_rx_lpi_from_line, i_fiber_unidir;
    logic [1:0] i_speed_select;
    logic [15:0] i_indicator_raw, o_indicator_outputs;
    logic [10:0] i_events;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int bad_count = 0;
    int tests_run = 0;
    integer seed = 59;
    logic [31:0] r;
    logic [15:0] ctl, sts;
    int i;

    // variant code is arbitrary, chosen only to differ from the default
    pep2_regs #(.P_INDUSTRIAL(1'b1), .P_VARIANT_BCD(8'h37)) u_dut (
        .i_clock(i_clock), .i_reset(i_reset), .i_soft_reset(i_soft_reset),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .i_link_up(i_link_up), .i_eee_1000_active(i_eee_1000_active),
        .i_eee_100_active(i_eee_100_active), .i_speed_select(i_speed_select),
        .i_mode_100(i_mode_100), .i_mode_1000(i_mode_1000),
        .i_tx_lpi_from_mac(i_tx_lpi_from_mac), .i_rx_lpi_from_line(i_rx_lpi_from_line),
        .i_fiber_unidir(i_fiber_unidir), .i_indicator_raw(i_indicator_raw),
        .i_events(i_events), .o_indicator_outputs(o_indicator_outputs),
        .o_te10_enable(o_te10_enable), .o_force_1000(o_force_1000),
        .o_ignore_mac_data(o_ignore_mac_data), .o_tx_lpi_line(o_tx_lpi_line),
        .o_rx_lpi_mac(o_rx_lpi_mac), .o_irq(o_irq)
    );

    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end

    task automatic tally_and_finish();
        $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            $display("Error at %0t: got %h expected %h", $time, g, e);
            bad_count++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
    endtask

    // one access; a read notes its expectation for the watcher before it starts
    task automatic bus(input logic wr, input logic [6:0] a, input logic [15:0] d,
                       input logic [3:0] be, input logic [31:0] m);
        int n;
        if (!wr) begin
            exp_q.push_back({16'h0000, d});
            msk_q.push_back(m);
        end
        i_avs_address <= a;
        i_avs_writedata <= {16'h0000, d};
        i_avs_byteenable <= be;
        i_avs_read <= !wr;
        i_avs_write <= wr;
        // look at waitrequest mid-cycle, where it has settled; the next rising edge takes it
        for (n = 0; n < 40; n++) begin
            @(negedge i_clock);
            if (o_avs_waitrequest === 1'b0) break;
        end
        if (n == 40) begin
            bad_count++;
            tally_and_finish();
        end
        @(posedge i_clock);
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        @(posedge i_clock);
    endtask

    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        bus(1'b0, a, e, 4'hf, 32'hffffffff);
    endtask

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        bus(1'b1, a, d, 4'hf, 32'h0);
    endtask

    // readdata stands through the answer cycle, so it is read mid-cycle
    always @(negedge i_clock) begin
        if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                chk(o_avs_readdata & msk_q[0], exp_q[0] & msk_q[0]);
                void'(exp_q.pop_front());
                void'(msk_q.pop_front());
            end
        end
    end

    function automatic logic [15:0] ind_exp(input logic [15:0] c, input logic [15:0] raw,
                                            input logic uni);
        logic [15:0] v;
        for (int g = 0; g < 4; g++) begin
            v[4*g+:4] = (uni && !c[14]) ? {4{~c[10+g]}} : ~raw[4*g+:4] ^ {4{c[10+g]}};
        end
        return v;
    endfunction

    initial begin
        {i_reset, i_soft_reset, i_avs_read, i_avs_write} = 4'h8;
        i_avs_address = 7'h00;
        i_avs_writedata = 32'h0;
        i_avs_byteenable = 4'hf;
        {i_link_up, i_eee_1000_active, i_eee_100_active, i_mode_100, i_mode_1000} = 5'h00;
        {i_tx_lpi_from_mac, i_rx_lpi_from_line, i_fiber_unidir} = 3'h0;
        i_speed_select = 2'h0;
        i_indicator_raw = 16'h0000;
        i_events = 11'h000;
        tick(3);
        i_reset <= 1'b0;
        tick(1);
        chk({o_te10_enable, o_force_1000, o_ignore_mac_data, o_irq}, 4'h0);
        chk(o_indicator_outputs, 16'hffff);
        wr(A_CTRL, 16'hffff);
        rd(A_CTRL, 16'h0000);
        wr(A_PAGE, 16'h0002);
        rd(A_PAGE, 16'h0002);
        {i_link_up, i_eee_1000_active, i_eee_100_active} <= 3'h5;
        rd(A_CTRL, 16'h0140);
        bus(1'b1, A_CTRL, 16'hffff, 4'hc, 32'h0);
        rd(A_CTRL, 16'h0140);
        wr(A_CHIP, 16'h0000);
        rd(A_CHIP, 16'hd537);
        bus(1'b0, A_ENT, 16'h0000, 4'hf, 32'hffff0000);
        rd(7'h50, 16'h0000);
        for (i = 0; i < 16; i++) begin
            r = $random(seed);
            ctl = r[15:0];
            {i_link_up, i_eee_1000_active, i_eee_100_active, i_speed_select} <= r[20:16];
            {i_mode_100, i_tx_lpi_from_mac, i_rx_lpi_from_line, i_fiber_unidir} <= r[24:21];
            i_mode_1000 <= ~r[24];
            i_indicator_raw <= r[31:16];
            wr(A_CTRL, ctl);
            rd(A_CTRL, (ctl & 16'hfc3f) | {7'h0, r[20:18], 6'h0});
            tick(1);
            chk(o_te10_enable, ctl[15]);
            chk(o_indicator_outputs, ind_exp(ctl, r[31:16], r[21]));
            chk(o_force_1000, ctl[5] && r[17:16] == 2'h2);
            chk(o_ignore_mac_data, ctl[4]);
            chk(o_tx_lpi_line, ctl[4] | r[23] & !(r[24] & ctl[3]) & !(!r[24] & ctl[1]));
            chk(o_rx_lpi_mac, r[22] & !(r[24] & ctl[2]) & !(!r[24] & ctl[0]));
        end
        r = $random(seed);
        wr(A_MASK, r[15:0]);
        rd(A_MASK, r[15:0] & 16'h07ff);
        wr(A_MASK, 16'h0555);
        for (i = 0; i < 11; i++) begin
            i_events <= 11'h001 << i;
            tick(1);
            i_events <= 11'h000;
            tick(2);
            chk(o_irq, i % 2 == 0);
            rd(A_STAT, 16'h0001 << i);
            rd(A_STAT, 16'h0000);
            chk(o_irq, 1'b0);
        end
        i_events <= 11'h400;
        tick(1);
        i_events <= 11'h000;
        i_soft_reset <= 1'b1;
        tick(1);
        i_soft_reset <= 1'b0;
        tick(1);
        rd(A_PAGE, 16'h0000);
        wr(A_PAGE, 16'h0002);
        rd(A_MASK, 16'h0555);
        rd(A_CTRL, (ctl & 16'hfc3f) | {7'h0, i_link_up, i_eee_1000_active, i_eee_100_active, 6'h0});
        rd(A_STAT, 16'h0000);
        wr(A_PAGE, 16'h0000);
        rd(A_MASK, 16'h0000);
        tick(4);
        tally_and_finish();
    end
endmodule
